/* File: smbus_slave_pkg.sv */
package smbus_slave_pkg;

    // Register pointer, data, fault flag and address index widths
    localparam int PTR_W = 3;
    localparam int DATA_W = 8;
    localparam int FAULT_W = 8;
    localparam int IDX_W = 5;

    // Fixed top bits of the own address and the two special addresses
    localparam logic [1:0] ADDR_PREFIX = 2'h2;
    localparam logic [6:0] BROADCAST_ADDR = 7'h5F;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
    localparam logic ALERT_RESP_TAIL = 1'h0;

    // Sensed state of a three-level address pin
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h1;
    localparam logic [1:0] PIN_OPEN = 2'h2;

    // Address index building blocks: group by pin 2, offset by pins 1 and 0
    localparam logic [IDX_W-1:0] GRP_LOW = 5'h00;
    localparam logic [IDX_W-1:0] GRP_OPEN = 5'h08;
    localparam logic [IDX_W-1:0] GRP_HIGH = 5'h10;
    localparam logic [IDX_W-1:0] EXTRA_BASE = 5'h18;
    localparam logic [IDX_W-1:0] OFS_OPEN_LOW = 5'h00;
    localparam logic [IDX_W-1:0] OFS_HIGH_OPEN = 5'h01;
    localparam logic [IDX_W-1:0] OFS_OPEN_OPEN = 5'h02;
    localparam logic [IDX_W-1:0] OFS_OPEN_HIGH = 5'h03;
    localparam logic [IDX_W-1:0] OFS_LOW_LOW = 5'h04;
    localparam logic [IDX_W-1:0] OFS_HIGH_HIGH = 5'h05;
    localparam logic [IDX_W-1:0] OFS_LOW_OPEN = 5'h06;
    localparam logic [IDX_W-1:0] OFS_LOW_HIGH = 5'h07;
    localparam logic [IDX_W-1:0] EXTRA_LOW = 5'h00;
    localparam logic [IDX_W-1:0] EXTRA_OPEN = 5'h01;
    localparam logic [IDX_W-1:0] EXTRA_HIGH = 5'h02;

    // Bit counter values of the eighth and first bit of a byte, and its step
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_STEP = 3'h1;

    // Open-drain pins only ever drive low
    localparam logic PIN_DRIVE_LEVEL = 1'h0;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_ADDR,
        LS_CMD,
        LS_WDATA,
        LS_ACK,
        LS_TX,
        LS_TX_ACK
    } link_state_type;

    typedef struct packed {
        link_state_type st;
        link_state_type rx_next;
        logic [2:0] cnt;
        logic [DATA_W-1:0] shift;
        logic [DATA_W-1:0] txd;
        logic [PTR_W-1:0] ptr;
        logic [DATA_W-1:0] wdata;
        logic drive;
        logic is_read;
        logic is_ara;
        logic got_data;
        logic start_seen;
        logic ptr_tgl;
        logic wr_tgl;
        logic rd_tgl;
        logic rel_tgl;
        logic alert_s1;
        logic alert_s2;
        logic bc_s1;
        logic bc_s2;
        logic [IDX_W-1:0] own_s1;
        logic [IDX_W-1:0] own_s2;
    } link_type;

    typedef struct packed {
        logic rel_d;
        logic wr_d;
        logic ptr_d;
        logic rd_d;
        logic [FAULT_W-1:0] armed_prev;
        logic alert;
        logic wr_en;
        logic [DATA_W-1:0] wr_data;
        logic [PTR_W-1:0] reg_ptr;
        logic [DATA_W-1:0] rd_hold;
    } sys_type;

    typedef struct packed {
        logic [1:0] pin2;
        logic [1:0] pin1;
        logic [1:0] pin0;
    } addr_pins_type;

    localparam link_type LINK_RST = '0;
    localparam sys_type SYS_RST = '0;

endpackage

/* File: bit_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second
module bit_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_type;

    sync_type sync_r;
    sync_type sync_nxt;

    always_comb begin
        sync_nxt = sync_r;
        sync_nxt.s1 = d_i;
        sync_nxt.s2 = sync_r.s1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign q_o = sync_r.s2;

endmodule

`default_nettype wire

/* File: addr_strap.sv */
`timescale 1ns/10ps
`default_nettype none

// Catches the three-level address straps once after reset release
module addr_strap (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire smbus_slave_pkg::addr_pins_type pins_i,
    output logic [smbus_slave_pkg::IDX_W-1:0] own_idx_o
);

    // Edges after release before the synchroniser shows the pins
    localparam logic [1:0] FLUSH_WAIT = 2'h2;

    typedef struct packed {
        logic [1:0] wait_cnt;
        logic done;
        logic [smbus_slave_pkg::IDX_W-1:0] idx;
    } strap_type;

    strap_type strap_r;
    strap_type strap_nxt;
    smbus_slave_pkg::addr_pins_type pins_q;

    function automatic logic [smbus_slave_pkg::IDX_W-1:0] pair_ofs(
        input logic [1:0] p1,
        input logic [1:0] p0
    );
        logic [smbus_slave_pkg::IDX_W-1:0] o;
        o = smbus_slave_pkg::OFS_OPEN_OPEN;
        // Undefined sense code is taken as open
        unique case ({p1 == smbus_slave_pkg::PIN_HIGH ? 2'h1 :
                      p1 == smbus_slave_pkg::PIN_LOW ? 2'h0 : 2'h2,
                      p0 == smbus_slave_pkg::PIN_HIGH ? 2'h1 :
                      p0 == smbus_slave_pkg::PIN_LOW ? 2'h0 : 2'h2})
            4'h8: o = smbus_slave_pkg::OFS_OPEN_LOW;
            4'h6: o = smbus_slave_pkg::OFS_HIGH_OPEN;
            4'hA: o = smbus_slave_pkg::OFS_OPEN_OPEN;
            4'h9: o = smbus_slave_pkg::OFS_OPEN_HIGH;
            4'h0: o = smbus_slave_pkg::OFS_LOW_LOW;
            4'h5: o = smbus_slave_pkg::OFS_HIGH_HIGH;
            4'h2: o = smbus_slave_pkg::OFS_LOW_OPEN;
            4'h1: o = smbus_slave_pkg::OFS_LOW_HIGH;
            default: o = smbus_slave_pkg::OFS_OPEN_OPEN;
        endcase
        return o;
    endfunction

    function automatic logic [smbus_slave_pkg::IDX_W-1:0] strap_index(
        input smbus_slave_pkg::addr_pins_type p
    );
        logic [smbus_slave_pkg::IDX_W-1:0] r;
        r = '0;
        if (p.pin1 == smbus_slave_pkg::PIN_HIGH && p.pin0 == smbus_slave_pkg::PIN_LOW) begin
            if (p.pin2 == smbus_slave_pkg::PIN_LOW) begin
                r = smbus_slave_pkg::EXTRA_BASE + smbus_slave_pkg::EXTRA_LOW;
            end else if (p.pin2 == smbus_slave_pkg::PIN_HIGH) begin
                r = smbus_slave_pkg::EXTRA_BASE + smbus_slave_pkg::EXTRA_HIGH;
            end else begin
                r = smbus_slave_pkg::EXTRA_BASE + smbus_slave_pkg::EXTRA_OPEN;
            end
        end else if (p.pin2 == smbus_slave_pkg::PIN_LOW) begin
            r = smbus_slave_pkg::GRP_LOW + pair_ofs(p.pin1, p.pin0);
        end else if (p.pin2 == smbus_slave_pkg::PIN_HIGH) begin
            r = smbus_slave_pkg::GRP_HIGH + pair_ofs(p.pin1, p.pin0);
        end else begin
            r = smbus_slave_pkg::GRP_OPEN + pair_ofs(p.pin1, p.pin0);
        end
        return r;
    endfunction

    bit_sync #(
        .W(6)
    ) pin_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .d_i(pins_i),
        .q_o(pins_q)
    );

    always_comb begin
        strap_nxt = strap_r;
        // Wait until the synchroniser has flushed its reset value
        if (!strap_r.done) begin
            if (strap_r.wait_cnt == FLUSH_WAIT) begin
                strap_nxt.idx = strap_index(pins_q);
                strap_nxt.done = 1'b1;
            end else begin
                strap_nxt.wait_cnt = strap_r.wait_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            strap_r <= '0;
        end else begin
            strap_r <= strap_nxt;
        end
    end

    assign own_idx_o = strap_r.idx;

endmodule

`default_nettype wire

/* File: smbus_slave_addr_alert.sv */
// Notes on behaviour
// - own address from three three-level pins
// - top two address bits fixed at one-zero
// - pin combinations map per address table
// - accept writes to broadcast address too
// - broadcast acceptance gated by enable bit
// - alert response: ack, send address, release
// - reply is seven address bits plus zero
// - transmitter releases data during ack pulse
// - receiver holds data low through ack
// - write: address, command low bits to pointer
// - first data byte acked and stored
// - further write bytes acked, discarded
// - read: repeated start, return pointed register
// - master ack repeats same register byte
// - alert asserted on enabled fault flag
// - own address access releases alert
// - released alert rearms only on new edge
// - byte and word read and write formats; a word carries only one register byte
`timescale 1ns/10ps
`default_nettype none

module smbus_slave_addr_alert (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic scl_clk_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [1:0] addr_select_pin_0_i,
    input wire logic [1:0] addr_select_pin_1_i,
    input wire logic [1:0] addr_select_pin_2_i,
    input wire logic broadcast_write_enable_bit_i,
    input wire logic [smbus_slave_pkg::FAULT_W-1:0] fault_i,
    input wire logic [smbus_slave_pkg::FAULT_W-1:0] alert_en_i,
    output logic [smbus_slave_pkg::PTR_W-1:0] reg_ptr_o,
    output logic reg_wr_o,
    output logic [smbus_slave_pkg::DATA_W-1:0] reg_wdata_o,
    input wire logic [smbus_slave_pkg::DATA_W-1:0] rd_data_i,
    output logic alert_o,
    output logic alert_oe_o
);

    smbus_slave_pkg::link_type lr;
    smbus_slave_pkg::link_type ln;
    smbus_slave_pkg::sys_type sr;
    smbus_slave_pkg::sys_type sn;
    smbus_slave_pkg::addr_pins_type pins;

    logic sda_rise_r;
    logic start_tgl_r;
    logic [smbus_slave_pkg::IDX_W-1:0] own_idx;
    logic [3:0] tgl_q;
    logic [smbus_slave_pkg::DATA_W-1:0] rx;
    logic [6:0] own_addr;
    logic own_hit;
    logic bc_hit;
    logic ara_hit;
    logic [smbus_slave_pkg::FAULT_W-1:0] armed;
    logic [smbus_slave_pkg::FAULT_W-1:0] new_fault;

    assign pins = '{pin2: addr_select_pin_2_i, pin1: addr_select_pin_1_i,
                    pin0: addr_select_pin_0_i};

    addr_strap strap (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .pins_i(pins),
        .own_idx_o(own_idx)
    );

    // Start marker: data falling while the clock is high
    always_ff @(negedge sda_i or posedge srst_i) begin
        if (srst_i) begin
            start_tgl_r <= 1'b0;
        end else if (scl_clk_i) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    // Received bit is taken on the rising clock edge
    always_ff @(posedge scl_clk_i or posedge srst_i) begin
        if (srst_i) begin
            sda_rise_r <= 1'b0;
        end else begin
            sda_rise_r <= sda_i;
        end
    end

    assign rx = {lr.shift[6:0], sda_rise_r};
    assign own_addr = {smbus_slave_pkg::ADDR_PREFIX, lr.own_s2};
    assign own_hit = rx[7:1] == own_addr;
    assign bc_hit = rx[7:1] == smbus_slave_pkg::BROADCAST_ADDR
                    && lr.bc_s2 && !rx[0];
    assign ara_hit = rx[7:1] == smbus_slave_pkg::ALERT_RESP_ADDR
                     && rx[0] && lr.alert_s2;

    // Link logic advances on the falling clock edge so the data line
    // changes only while the clock is low
    always_comb begin
        ln = lr;
        ln.alert_s1 = sr.alert;
        ln.alert_s2 = lr.alert_s1;
        ln.bc_s1 = broadcast_write_enable_bit_i;
        ln.bc_s2 = lr.bc_s1;
        ln.own_s1 = own_idx;
        ln.own_s2 = lr.own_s1;
        ln.start_seen = start_tgl_r;
        if (lr.start_seen != start_tgl_r) begin
            ln.st = smbus_slave_pkg::LS_ADDR;
            ln.cnt = smbus_slave_pkg::BIT_FIRST;
            ln.drive = 1'b0;
        end else begin
            unique case (lr.st)
                smbus_slave_pkg::LS_IDLE: begin
                    ln.drive = 1'b0;
                end
                smbus_slave_pkg::LS_ADDR,
                smbus_slave_pkg::LS_CMD,
                smbus_slave_pkg::LS_WDATA: begin
                    ln.shift = rx;
                    ln.cnt = lr.cnt + smbus_slave_pkg::BIT_STEP;
                    if (lr.cnt == smbus_slave_pkg::BIT_LAST) begin
                        ln.st = smbus_slave_pkg::LS_ACK;
                        ln.drive = 1'b1;
                        if (lr.st == smbus_slave_pkg::LS_ADDR) begin
                            ln.is_read = rx[0];
                            ln.is_ara = 1'b0;
                            ln.got_data = 1'b0;
                            ln.rx_next = smbus_slave_pkg::LS_CMD;
                            if (own_hit) begin
                                ln.rel_tgl = ~lr.rel_tgl;
                                ln.rd_tgl = rx[0] ? ~lr.rd_tgl : lr.rd_tgl;
                            end else if (ara_hit) begin
                                ln.is_ara = 1'b1;
                            end else if (!bc_hit) begin
                                ln.st = smbus_slave_pkg::LS_IDLE;
                                ln.drive = 1'b0;
                            end
                        end else if (lr.st == smbus_slave_pkg::LS_CMD) begin
                            ln.ptr = rx[smbus_slave_pkg::PTR_W-1:0];
                            ln.ptr_tgl = ~lr.ptr_tgl;
                            ln.rx_next = smbus_slave_pkg::LS_WDATA;
                        end else begin
                            ln.rx_next = smbus_slave_pkg::LS_WDATA;
                            // Second and later bytes acked but dropped
                            if (!lr.got_data) begin
                                ln.wdata = rx;
                                ln.wr_tgl = ~lr.wr_tgl;
                                ln.got_data = 1'b1;
                            end
                        end
                    end
                end
                smbus_slave_pkg::LS_ACK: begin
                    ln.cnt = smbus_slave_pkg::BIT_FIRST;
                    if (lr.is_read) begin
                        // Reply byte; read data was fetched during the address ack
                        ln.txd = lr.is_ara ? {own_addr, smbus_slave_pkg::ALERT_RESP_TAIL}
                                           : sr.rd_hold;
                        ln.shift = {ln.txd[6:0], 1'b0};
                        ln.drive = ~ln.txd[7];
                        ln.st = smbus_slave_pkg::LS_TX;
                    end else begin
                        ln.drive = 1'b0;
                        ln.st = lr.rx_next;
                    end
                end
                smbus_slave_pkg::LS_TX: begin
                    ln.cnt = lr.cnt + smbus_slave_pkg::BIT_STEP;
                    if (lr.cnt == smbus_slave_pkg::BIT_LAST) begin
                        ln.drive = 1'b0;
                        ln.st = smbus_slave_pkg::LS_TX_ACK;
                    end else begin
                        ln.drive = ~lr.shift[7];
                        ln.shift = {lr.shift[6:0], 1'b0};
                    end
                end
                smbus_slave_pkg::LS_TX_ACK: begin
                    ln.cnt = smbus_slave_pkg::BIT_FIRST;
                    if (lr.is_ara) begin
                        ln.rel_tgl = ~lr.rel_tgl;
                        ln.st = smbus_slave_pkg::LS_IDLE;
                    end else if (!sda_rise_r) begin
                        ln.shift = {lr.txd[6:0], 1'b0};
                        ln.drive = ~lr.txd[7];
                        ln.st = smbus_slave_pkg::LS_TX;
                    end else begin
                        ln.st = smbus_slave_pkg::LS_IDLE;
                    end
                end
                default: begin
                    ln.st = smbus_slave_pkg::LS_IDLE;
                    ln.drive = 1'b0;
                end
            endcase
        end
    end

    // Clock stops between frames, so reset cannot wait for an edge here
    always_ff @(negedge scl_clk_i or posedge srst_i) begin
        if (srst_i) begin
            lr <= smbus_slave_pkg::LINK_RST;
        end else begin
            lr <= ln;
        end
    end

    // Event toggles from the link: release, write, pointer, read fetch
    bit_sync #(
        .W(4)
    ) evt_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .d_i({lr.rel_tgl, lr.wr_tgl, lr.ptr_tgl, lr.rd_tgl}),
        .q_o(tgl_q)
    );

    assign armed = fault_i & alert_en_i;
    assign new_fault = armed & ~sr.armed_prev;

    // Pointer and write data are stable long before their toggle lands
    always_comb begin
        sn = sr;
        sn.rel_d = tgl_q[3];
        sn.wr_d = tgl_q[2];
        sn.ptr_d = tgl_q[1];
        sn.rd_d = tgl_q[0];
        sn.armed_prev = armed;
        sn.wr_en = 1'b0;
        if (tgl_q[1] != sr.ptr_d) begin
            sn.reg_ptr = lr.ptr;
        end
        if (tgl_q[2] != sr.wr_d) begin
            sn.wr_en = 1'b1;
            sn.wr_data = lr.wdata;
            sn.reg_ptr = lr.ptr;
        end
        if (tgl_q[0] != sr.rd_d) begin
            sn.rd_hold = rd_data_i;
        end
        // A fresh fault wins over a release in the same cycle
        if (|new_fault) begin
            sn.alert = 1'b1;
        end else if (tgl_q[3] != sr.rel_d) begin
            sn.alert = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sr <= smbus_slave_pkg::SYS_RST;
        end else begin
            sr <= sn;
        end
    end

    assign sda_o = smbus_slave_pkg::PIN_DRIVE_LEVEL;
    assign sda_oe_o = lr.drive;
    assign reg_ptr_o = sr.reg_ptr;
    assign reg_wr_o = sr.wr_en;
    assign reg_wdata_o = sr.wr_data;
    assign alert_o = smbus_slave_pkg::PIN_DRIVE_LEVEL;
    assign alert_oe_o = sr.alert;

endmodule

`default_nettype wire

/* File: smbus_slave_addr_alert_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_addr_alert_sva (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic scl_clk_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [smbus_slave_pkg::FAULT_W-1:0] fault_i,
    input wire logic [smbus_slave_pkg::FAULT_W-1:0] alert_en_i,
    input wire logic reg_wr_o,
    input wire logic [smbus_slave_pkg::DATA_W-1:0] reg_wdata_o,
    input wire logic alert_o,
    input wire logic alert_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic [smbus_slave_pkg::FAULT_W-1:0] armed_q;
    logic [7:0] idle_cnt;
    wire logic new_edge = |((fault_i & alert_en_i) & ~armed_q);
    // Cycles since the device last pulled the data line, saturating
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            armed_q <= '0;
            idle_cnt <= 8'hFF;
        end else begin
            armed_q <= fault_i & alert_en_i;
            if (sda_oe_o) begin
                idle_cnt <= 8'h00;
            end else if (idle_cnt != 8'hFF) begin
                idle_cnt <= idle_cnt + 8'h01;
            end
        end
    end
    open_drain_a: assert property (sda_o == 1'b0 && alert_o == 1'b0)
        else $error("open-drain data level not low");
    alert_raise_a: assert property (new_edge |-> ##[1:2] alert_oe_o)
        else $error("alert not raised on enabled fault edge");
    alert_cause_a: assert property ($rose(alert_oe_o) |-> $past(new_edge) || $past(new_edge, 2))
        else $error("alert raised without a new fault edge");
    oe_on_low_a: assert property ($changed(sda_oe_o) |-> !scl_clk_i)
        else $error("data drive changed while bus clock high");
    wr_pulse_a: assert property (reg_wr_o |=> !reg_wr_o)
        else $error("write strobe longer than one cycle");
    wdata_hold_a: assert property ($changed(reg_wdata_o) |-> reg_wr_o)
        else $error("write data changed without strobe");
    wr_cause_a: assert property (reg_wr_o |-> idle_cnt < 8'h0C)
        else $error("write strobe without acknowledged byte");
    release_cause_a: assert property ($fell(alert_oe_o) |-> idle_cnt < 8'h30)
        else $error("alert released without bus access");
    cover property ($rose(alert_oe_o));
    cover property ($fell(alert_oe_o));
    cover property (reg_wr_o);
endmodule
`default_nettype wire

/* File: smbus_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module smbus_master_model (
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    localparam realtime Q = 31.25;
    // Clock stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // Also serves as repeated start from a low clock
    task automatic start();
        sda_low_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b1;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_low_o = 1'b0;
        #Q;
    endtask
    task automatic clk_bit(input logic b, output logic s);
        sda_low_o = !b;
        #Q scl_o = 1'b1;
        #Q s = sda_i;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    // Sending releases the line in the ninth slot; reading acks with ack_in low
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
        clk_bit(ack_in, ack);
    endtask
endmodule
`default_nettype wire

/* File: smbus_slave_addr_alert_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_addr_alert_bench;
    logic sys_clk, srst, scl, m_low, sda, sda_o, sda_oe, bc_en, reg_wr, alert_o, alert_oe, ack;
    smbus_slave_pkg::addr_pins_type pins;
    logic [7:0] fault, alert_en, reg_wdata, rx;
    logic [7:0] rd_data = 8'h00;
    logic [2:0] reg_ptr;
    int failures, total_checks, cycles, wr_count, n0;
    // Pull-up on the data line
    assign sda = !(m_low | sda_oe);
    smbus_master_model m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
    smbus_slave_addr_alert dut_u (.sys_clk_i(sys_clk), .srst_i(srst), .scl_clk_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_pin_0_i(pins.pin0),
        .addr_select_pin_1_i(pins.pin1), .addr_select_pin_2_i(pins.pin2),
        .broadcast_write_enable_bit_i(bc_en), .fault_i(fault), .alert_en_i(alert_en),
        .reg_ptr_o(reg_ptr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .rd_data_i(rd_data),
        .alert_o(alert_o), .alert_oe_o(alert_oe));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic [7:0] exp_ack);
        m.xfer(b, 1'b1, rx, ack);
        check({7'h00, ack}, exp_ack);
    endtask
    task automatic wait_sys(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic do_reset(input logic [5:0] p);
        @(posedge sys_clk);
        srst <= 1'b1;
        pins <= p;
        wait_sys(20);
        srst <= 1'b0;
        wait_sys(24);
    endtask
    // Straps are caught once after reset, so each entry needs its own reset
    task automatic t_addr_map();
        logic [5:0] pin_tab [3] = '{6'h19, 6'h04, 6'h2A};
        logic [6:0] adr_tab [3] = '{7'h53, 7'h58, 7'h4A};
        for (int i = 0; i < 3; i++) begin
            do_reset(pin_tab[i]);
            m.start();
            send({adr_tab[i] ^ 7'h01, 1'b0}, 8'h01);
            m.stop();
            m.start();
            send({adr_tab[i], 1'b0}, 8'h00);
            m.stop();
        end
    endtask
    task automatic t_write();
        n0 = wr_count;
        m.start();
        send(8'h94, 8'h00);
        send(8'hFD, 8'h00);
        send(8'h5C, 8'h00);
        send(8'hA3, 8'h00);
        m.stop();
        wait_sys(8);
        check({5'h00, reg_ptr}, 8'h05);
        check(reg_wdata, 8'h5C);
        check(8'(wr_count - n0), 8'h01);
    endtask
    task automatic t_read();
        m.start();
        send(8'h94, 8'h00);
        send(8'h02, 8'h00);
        m.start();
        send(8'h95, 8'h00);
        m.xfer(8'hFF, 1'b0, rx, ack);
        check(rx, 8'hC2);
        m.xfer(8'hFF, 1'b1, rx, ack);
        check(rx, 8'hC2);
        m.stop();
    endtask
    task automatic t_refuse();
        wait_sys(1);
        bc_en <= 1'b1;
        m.start();
        send(8'hBE, 8'h00);
        send(8'h03, 8'h00);
        send(8'h77, 8'h00);
        m.stop();
        wait_sys(8);
        check({5'h00, reg_ptr}, 8'h03);
        check(reg_wdata, 8'h77);
        m.start();
        send(8'hBF, 8'h01);
        m.stop();
        wait_sys(1);
        bc_en <= 1'b0;
        m.start();
        send(8'hBE, 8'h01);
        m.stop();
        m.start();
        send(8'h19, 8'h01);
        m.stop();
    endtask
    task automatic t_alert();
        wait_sys(1);
        alert_en <= 8'h05;
        fault <= 8'h02;
        wait_sys(4);
        check({7'h00, alert_oe}, 8'h00);
        fault <= 8'h06;
        wait_sys(4);
        check({7'h00, alert_oe}, 8'h01);
        m.start();
        send(8'h19, 8'h00);
        m.xfer(8'hFF, 1'b1, rx, ack);
        check(rx, 8'h94);
        m.stop();
        wait_sys(16);
        check({7'h00, alert_oe}, 8'h00);
        fault <= 8'h07;
        wait_sys(4);
        check({7'h00, alert_oe}, 8'h01);
        m.start();
        send(8'h94, 8'h00);
        m.stop();
        wait_sys(8);
        check({7'h00, alert_oe}, 8'h00);
        fault <= 8'h03;
        wait_sys(4);
        fault <= 8'h07;
        wait_sys(4);
        check({7'h00, alert_oe}, 8'h01);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = !sys_clk;
    end
    // Register file stand-in and run limit
    always @(posedge sys_clk) begin
        cycles++;
        if (reg_wr === 1'b1) wr_count++;
        rd_data <= {5'h18, reg_ptr};
        if (cycles == 40000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        srst = 1'b1;
        pins = 6'h2A;
        bc_en = 1'b0;
        fault = 8'h00;
        alert_en = 8'h00;
        t_addr_map();
        t_write();
        t_read();
        t_refuse();
        t_alert();
        complete_run();
    end
endmodule
bind smbus_slave_addr_alert smbus_slave_addr_alert_sva sva_u (.sys_clk_i(sys_clk_i),
    .srst_i(srst_i), .scl_clk_i(scl_clk_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .fault_i(fault_i), .alert_en_i(alert_en_i), .reg_wr_o(reg_wr_o),
    .reg_wdata_o(reg_wdata_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o));
`default_nettype wire
